// ==== tc_far_side.sv ====
// Far-side model: two sensors, fault lines, relay contact and buttons.
`timescale 1ns/1ps
module tc_far_side (
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire logic signed [15:0] temp_a,
  input  wire logic signed [15:0] temp_b,
  input  wire logic [3:0]         flt_in,
  input  wire logic [3:0]         btn_in,
  input  wire logic               relay_dead,
  input  wire logic               heat,
  output tc_pkg::pin_s            pins
);
  import tc_pkg::*;
  // ---------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------
  typedef struct packed {
    pin_s pins;
    logic stuck;
  } far_s;
  far_s state_ff;
  far_s nxt_state;
  // A dead relay is only noticed once the drive asks for it, as a real
  // contact that fails to close would be; it then stays until repaired.
  always_comb begin
    nxt_state = state_ff;
    nxt_state.stuck = relay_dead & (state_ff.stuck | heat);
    nxt_state.pins.ta = temp_a;
    nxt_state.pins.tb = temp_b;
    nxt_state.pins.btn = btn_in;
    nxt_state.pins.flt = flt_in | {state_ff.stuck, 3'h0};
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end
  assign pins = state_ff.pins;
endmodule // tc_far_side

// ==== tc_output_logic.sv ====
// Decision, limiter, fault and status LED logic of the controller.
`timescale 1ns/1ps
// Overview of operation
// R1 - Self-test white, then brief green, then run
// R2 - Steady green inside good range
// R3 - Slow blue flash below good range
// R4 - Slow red flash above good range
// R5 - Slow yellow flash while limiter exceeded
// R6 - Four fault inputs watched at all times
// R7 - Fault cuts output, fast flash per class
// R8 - Acknowledge clears only vanished faults
// R9 - Cleared fault returns to normal control
// R10 - Up+down toggles on; enter+back opens menu
// R11 - Setpoint always clamped to limits (clamped on A_SP write and edit steps; A_LO/A_HI writes do not re-clamp it)
// R12 - Enter commits edit, back aborts it
// R13 - Two-point switches at setpoint plus/minus range
// R14 - Fixed mode: percent of one minute on
// R15 - Deactivated mode: only limiter acts
// R16 - Good range 0.5 to 20 degrees
// R17 - Setpoint ramps at configured gradient
// R18 - Follower uses other sensor as setpoint
// R19 - Sensor choice independent for both functions
// R20 - Self-adjusting mode adapts switch-off point
// R21 - Limiter overrides control and cuts output
// R22 - Heater or cooler sense of demand
// R23 - Limiter releases below limit minus hysteresis
// R24 - Fifty-percent flashing, faults shown first (the self-test white is still shown ahead of faults)
// R25 - Combinations need debounced stable buttons
module tc_output_logic #(
  parameter int SLOW_HALF = tc_pkg::CLK_HZ / (2 * tc_pkg::SLOW_HZ),
  parameter int FAST_HALF = tc_pkg::CLK_HZ / (2 * tc_pkg::FAST_HZ),
  parameter int DEB_CYC   = tc_pkg::CLK_HZ / 1000 * tc_pkg::DEB_MS,
  parameter int TEST_CYC  = tc_pkg::CLK_HZ / 1000 * tc_pkg::TEST_MS,
  parameter int GREEN_CYC = tc_pkg::CLK_HZ / 1000 * tc_pkg::GREEN_MS
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire tc_pkg::pin_s pins,
  input  wire logic [7:0]   addr,
  input  wire logic [15:0]  wdata,
  input  wire logic         wr,
  input  wire logic         rd,
  output logic [15:0]       rdata,
  output tc_pkg::led_s      led,
  output logic              heat,
  output logic              menu,
  output logic              editing,
  output logic [15:0]       edit_val
);
  import tc_pkg::*;

  localparam logic [31:0] SLOW_END  = 32'(SLOW_HALF - 1);
  localparam logic [31:0] FAST_END  = 32'(FAST_HALF - 1);
  localparam logic [31:0] DEB_END   = 32'(DEB_CYC - 1);
  localparam logic [31:0] TEST_END  = 32'(TEST_CYC - 1);
  localparam logic [31:0] GREEN_END = 32'(GREEN_CYC - 1);

  // -----------------------------------------------------------------------
  // State
  // -----------------------------------------------------------------------
  typedef struct packed {
    pin_s               p1;
    pin_s               p2;
    logic [3:0]         bcand;
    logic [3:0]         bst;
    logic [3:0]         bold;
    logic [31:0]        dcnt;
    logic               combo;
    logic [31:0]        scnt;
    logic               sph;
    logic [31:0]        fcnt;
    logic               fph;
    logic [5:0]         secs;
    phase_e             ph;
    logic [31:0]        tmr;
    logic [3:0]         flt;
    logic               on;
    mode_e              mode;
    logic               cool;
    logic               foll;
    logic               csel;
    logic               lsel;
    logic signed [15:0] lo;
    logic signed [15:0] hi;
    logic signed [15:0] rng;
    logic signed [15:0] lim;
    logic signed [15:0] hys;
    logic signed [15:0] grad;
    logic [6:0]         pct;
    logic signed [15:0] sp;
    logic signed [15:0] esp;
    logic signed [15:0] edv;
    logic               edit;
    logic               dem;
    logic               pk;
    logic signed [15:0] adj;
    logic               trip;
    led_s               led;
    logic               heat;
    logic               menu;
    logic [15:0]        rdata;
  } state_s;

  state_s             s;
  state_s             n;
  logic signed [15:0] t_ctl;
  logic signed [15:0] t_lim;
  logic signed [15:0] tgt;
  logic signed [15:0] err;
  logic signed [15:0] base;
  logic               sec_tick;
  logic [3:0]         rel;
  logic               fixed_on;

  function automatic logic signed [15:0] clampv(
    input logic signed [15:0] v,
    input logic signed [15:0] l,
    input logic signed [15:0] h);
    clampv = (v < l) ? l : ((v > h) ? h : v);
  endfunction

  // -----------------------------------------------------------------------
  // Next state
  // -----------------------------------------------------------------------
  always_comb begin
    n = s;
    n.p1 = pins;
    n.p2 = s.p1;
    n.menu = 1'b0;
    // Control and limiter may share or split the two inputs.
    t_ctl = s.csel ? s.p2.tb : s.p2.ta; // R19
    t_lim = s.lsel ? s.p2.tb : s.p2.ta; // R19
    tgt = s.foll ? (s.csel ? s.p2.ta : s.p2.tb) : s.sp; // R18
    // Mirroring the error lets one decision serve heater and cooler.
    err = s.cool ? (s.esp - t_ctl) : (t_ctl - s.esp); // R22
    base = s.edit ? s.edv : s.sp;
    // Flash timers; the slow falling phase doubles as the second tick.
    sec_tick = (s.scnt == SLOW_END) && s.sph;
    n.scnt = (s.scnt == SLOW_END) ? 32'h0 : s.scnt + 32'h1;
    n.sph = (s.scnt == SLOW_END) ? ~s.sph : s.sph; // R24
    n.fcnt = (s.fcnt == FAST_END) ? 32'h0 : s.fcnt + 32'h1;
    n.fph = (s.fcnt == FAST_END) ? ~s.fph : s.fph; // R24
    if (sec_tick) begin
      n.secs = (16'(s.secs) == PERIOD_S - 16'h1) ? 6'h0 : s.secs + 6'h1;
    end
    // Buttons count as pressed only after a stable debounce window.
    rel = 4'h0;
    n.bold = s.bst;
    if (s.p2.btn != s.bcand) begin
      n.bcand = s.p2.btn;
      n.dcnt = 32'h0;
    end else if (s.dcnt != DEB_END) begin
      n.dcnt = s.dcnt + 32'h1;
    end else begin
      n.bst = s.bcand; // R25
    end
    if (s.bst == B_UPDN && !s.combo) begin
      n.on = ~s.on; // R10
      n.combo = 1'b1;
    end
    if (s.bst == B_MENU && !s.combo) begin
      n.menu = 1'b1; // R10
      n.combo = 1'b1;
    end
    // Single presses act on release so a combination never leaks one.
    if (s.bold != 4'h0 && s.bst == 4'h0) begin
      n.combo = 1'b0;
      if (!s.combo) begin
        rel = s.bold;
      end
    end
    // Faults latch from power-up onward.
    n.flt = s.flt | s.p2.flt; // R6
    unique case (rel)
      B_UP: begin
        n.edv = clampv(base + ONE_STEP, s.lo, s.hi); // R11
        n.edit = 1'b1;
      end
      B_DN: begin
        n.edv = clampv(base - ONE_STEP, s.lo, s.hi); // R11
        n.edit = 1'b1;
      end
      B_ENTER: begin
        if (s.edit) begin
          n.sp = s.edv; // R12
          n.edit = 1'b0;
        end else begin
          n.flt = s.p2.flt; // R8 R9
        end
      end
      B_BACK: n.edit = 1'b0; // R12
      default: ;
    endcase
    // Setpoint ramp.
    if (s.grad <= 16'sh0) begin
      n.esp = tgt; // R17
    end else if (sec_tick && s.esp < tgt) begin
      n.esp = (tgt - s.esp > s.grad) ? s.esp + s.grad : tgt; // R17
    end else if (sec_tick && s.esp > tgt) begin
      n.esp = (s.esp - tgt > s.grad) ? s.esp - s.grad : tgt; // R17
    end
    // Limiter with release hysteresis.
    if (t_lim > s.lim) begin
      n.trip = 1'b1; // R21
    end else if (t_lim < s.lim - s.hys) begin
      n.trip = 1'b0; // R23
    end
    // Control decision.
    fixed_on = 16'(s.secs) * PCT_FULL < 16'(s.pct) * PERIOD_S; // R14
    unique case (s.mode)
      M_TWO: begin
        if (err < -s.rng) n.dem = 1'b1; // R13
        else if (err > s.rng) n.dem = 1'b0; // R13
      end
      M_SELF: begin
        // Overshoot past the band pulls the switch-off point in.
        if (!s.dem && err > s.rng) n.pk = 1'b1; // R20
        if (err < -s.rng && !s.dem) begin
          n.dem = 1'b1;
          n.pk = 1'b0;
          if (s.pk && s.adj < s.rng) n.adj = s.adj + ONE_STEP; // R20
          else if (!s.pk && s.adj > 16'sh0) n.adj = s.adj - ONE_STEP;
        end else if (err > s.rng - s.adj) begin
          n.dem = 1'b0; // R20
        end
      end
      M_FIXED: n.dem = fixed_on; // R14
      M_OFF: n.dem = 1'b1; // R15
    endcase
    n.heat = (s.ph == PH_RUN) && s.on && s.flt == 4'h0 // R7
      && !s.trip && s.dem; // R21
    // Power-up sequence.
    n.tmr = s.tmr + 32'h1;
    unique case (s.ph)
      PH_TEST: if (s.tmr == TEST_END) begin
        n.ph = PH_GREEN; // R1
        n.tmr = 32'h0;
      end
      PH_GREEN: if (s.tmr == GREEN_END) n.ph = PH_RUN; // R1
      PH_RUN: n.tmr = 32'h0;
      default: n.ph = PH_TEST;
    endcase
    // Status LED, self-test white first, then faults.
    if (s.ph == PH_TEST) begin
      n.led = LED_WHITE; // R1
    end else if ((s.flt & F_UNIT) != 4'h0) begin
      n.led = s.fph ? LED_RED : LED_OFF; // R7 R24
    end else if (s.flt[F_SENS]) begin
      n.led = s.fph ? LED_PURPLE : LED_OFF; // R7 R24
    end else if (s.ph == PH_GREEN) begin
      n.led = LED_GREEN; // R1
    end else if (s.trip) begin
      n.led = s.sph ? LED_YELLOW : LED_OFF; // R5
    end else if (t_ctl < s.esp - s.rng) begin
      n.led = s.sph ? LED_BLUE : LED_OFF; // R3
    end else if (t_ctl > s.esp + s.rng) begin
      n.led = s.sph ? LED_RED : LED_OFF; // R4
    end else begin
      n.led = LED_GREEN; // R2
    end
    // Register port.
    if (wr) begin
      unique case (addr)
        A_CTRL: begin
          n.mode = mode_e'(wdata[1:0]);
          n.cool = wdata[C_COOL];
          n.foll = wdata[C_FOLL];
          n.csel = wdata[C_CSEL];
          n.lsel = wdata[C_LSEL];
        end
        A_LO: n.lo = wdata;
        A_HI: n.hi = wdata;
        A_RANGE: n.rng = clampv(wdata, RANGE_MIN, RANGE_MAX); // R16
        A_LIMIT: n.lim = wdata;
        A_HYST: n.hys = wdata;
        A_PCT: n.pct = (wdata > PCT_FULL) ? 7'(PCT_FULL) : wdata[6:0];
        A_GRAD: n.grad = wdata;
        A_SP: n.sp = clampv(wdata, s.lo, s.hi); // R11
        default: ;
      endcase
    end
    n.rdata = 16'h0;
    if (rd) begin
      unique case (addr)
        A_CTRL: n.rdata = {10'h0, s.lsel, s.csel, s.foll, s.cool, s.mode};
        A_LO: n.rdata = s.lo;
        A_HI: n.rdata = s.hi;
        A_RANGE: n.rdata = s.rng;
        A_LIMIT: n.rdata = s.lim;
        A_HYST: n.rdata = s.hys;
        A_PCT: n.rdata = {9'h0, s.pct};
        A_GRAD: n.rdata = s.grad;
        A_SP: n.rdata = s.sp;
        A_STAT: n.rdata = {5'h0, s.ph, s.edit, s.trip, s.heat, s.on,
                           s.dem, s.flt};
        default: n.rdata = 16'h0;
      endcase
    end
  end

  // -----------------------------------------------------------------------
  // Registers
  // -----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      s.ph <= PH_TEST;
      s.on <= 1'b1;
      s.mode <= M_SELF;
      s.lo <= RST_LO;
      s.hi <= RST_HI;
      s.rng <= RST_RANGE;
      s.lim <= RST_LIMIT;
      s.hys <= RST_HYST;
      s.grad <= RST_GRAD;
      s.pct <= RST_PCT;
      s.sp <= RST_SP;
      s.esp <= RST_SP;
      s.edv <= RST_SP;
      s.led <= LED_WHITE;
    end else begin
      s <= n;
    end
  end

  assign rdata = s.rdata;
  assign led = s.led;
  assign heat = s.heat;
  assign menu = s.menu;
  assign editing = s.edit;
  assign edit_val = s.edv;

  // -----------------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence edit_commit;
    s.edit && rel == B_ENTER;
  endsequence
  sequence lim_over;
    s.trip && t_lim >= s.lim - s.hys;
  endsequence

  a_fault_cuts_heat: assert property (s.flt != 4'h0 |=> !heat) // R7
    else $error("Output on while a fault is latched.");
  a_trip_cuts_heat: assert property (s.trip |=> !heat) // R21
    else $error("Output on while limiter is tripped.");
  a_trip_holds: assert property (lim_over |=> s.trip) // R23
    else $error("Limiter released above the hysteresis point.");
  a_edit_commits: assert property (edit_commit |=> // R12
    s.sp == $past(s.edv) && !s.edit)
    else $error("Accepted value not taken as setpoint.");
  a_sp_in_limits: assert property (s.lo <= s.hi && // R11
    $past(wr) && $past(addr) == A_SP |-> s.sp >= s.lo && s.sp <= s.hi)
    else $error("Setpoint written outside its limits.");
  a_range_bounds: assert property (s.rng >= RANGE_MIN && // R16
    s.rng <= RANGE_MAX)
    else $error("Good range outside its bounds.");
  a_ack_keeps_fault: assert property (rel == B_ENTER && !s.edit // R8
    && s.p2.flt != 4'h0 |=> s.flt != 4'h0)
    else $error("Present fault cleared by acknowledge.");
  a_test_white: assert property (s.ph == PH_TEST |=> // R1
    led == LED_WHITE)
    else $error("Self-test not shown in white.");
  a_green_steady: assert property (s.ph == PH_RUN && // R2
    s.flt == 4'h0 && !s.trip && t_ctl >= s.esp - s.rng &&
    t_ctl <= s.esp + s.rng |=> led == LED_GREEN)
    else $error("In-range temperature not shown green.");
  a_unit_flash: assert property ((s.flt & F_UNIT) != 4'h0 // R7
    && s.ph != PH_TEST |=> led == ($past(s.fph) ? LED_RED : LED_OFF))
    else $error("Unit fault not flashing red.");
endmodule // tc_output_logic

// ==== tc_pkg.sv ====
// Shared types and constants of the temperature control output logic.
package tc_pkg;
  // ---------------------------------------------------------------------
  // Register map (byte addresses, 16-bit data in the low bits)
  // ---------------------------------------------------------------------
  localparam logic [7:0] A_CTRL  = 8'h00;
  localparam logic [7:0] A_LO    = 8'h04;
  localparam logic [7:0] A_HI    = 8'h08;
  localparam logic [7:0] A_RANGE = 8'h0C;
  localparam logic [7:0] A_LIMIT = 8'h10;
  localparam logic [7:0] A_HYST  = 8'h14;
  localparam logic [7:0] A_PCT   = 8'h18;
  localparam logic [7:0] A_GRAD  = 8'h1C;
  localparam logic [7:0] A_SP    = 8'h20;
  localparam logic [7:0] A_STAT  = 8'h24;
  // Control register fields.
  localparam int C_COOL = 2;
  localparam int C_FOLL = 3;
  localparam int C_CSEL = 4;
  localparam int C_LSEL = 5;
  // ---------------------------------------------------------------------
  // Reset values, temperatures in 0.1 degree units
  // ---------------------------------------------------------------------
  localparam logic signed [15:0] RST_LO    = 16'sh0000;
  localparam logic signed [15:0] RST_HI    = 16'sh07D0;
  localparam logic signed [15:0] RST_SP    = 16'sh01F4;
  localparam logic signed [15:0] RST_RANGE = 16'sh001E;
  localparam logic signed [15:0] RANGE_MIN = 16'sh0005;
  localparam logic signed [15:0] RANGE_MAX = 16'sh00C8;
  localparam logic signed [15:0] RST_LIMIT = 16'sh03E8;
  localparam logic signed [15:0] RST_HYST  = 16'sh0032;
  localparam logic signed [15:0] RST_GRAD  = 16'sh0000;
  localparam logic signed [15:0] ONE_STEP  = 16'sh0001;
  localparam logic [6:0]  RST_PCT  = 7'h19;
  localparam logic [15:0] PCT_FULL = 16'h0064;
  localparam logic [15:0] PERIOD_S = 16'h003C;
  // ---------------------------------------------------------------------
  // Timing in its own units
  // ---------------------------------------------------------------------
  localparam int CLK_HZ   = 25_000_000;
  localparam int SLOW_HZ  = 1;
  localparam int FAST_HZ  = 4;
  localparam int DEB_MS   = 20;
  localparam int TEST_MS  = 100;
  localparam int GREEN_MS = 1000;
  // ---------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------
  // Fault bits: board temperature, supply, sensor open, relay.
  localparam int F_SENS = 2;
  localparam logic [3:0] F_UNIT = 4'hB;
  // Buttons: up, down, enter, back.
  localparam logic [3:0] B_UP    = 4'h1;
  localparam logic [3:0] B_DN    = 4'h2;
  localparam logic [3:0] B_ENTER = 4'h4;
  localparam logic [3:0] B_BACK  = 4'h8;
  localparam logic [3:0] B_UPDN  = 4'h3;
  localparam logic [3:0] B_MENU  = 4'hC;
  typedef enum logic [1:0] {M_SELF, M_TWO, M_FIXED, M_OFF} mode_e;
  typedef enum logic [1:0] {PH_TEST, PH_GREEN, PH_RUN} phase_e;
  typedef struct packed {
    logic r;
    logic g;
    logic b;
  } led_s;
  localparam led_s LED_OFF    = 3'h0;
  localparam led_s LED_WHITE  = 3'h7;
  localparam led_s LED_GREEN  = 3'h2;
  localparam led_s LED_BLUE   = 3'h1;
  localparam led_s LED_RED    = 3'h4;
  localparam led_s LED_YELLOW = 3'h6;
  localparam led_s LED_PURPLE = 3'h5;
  typedef struct packed {
    logic signed [15:0] ta;
    logic signed [15:0] tb;
    logic [3:0]         flt;
    logic [3:0]         btn;
  } pin_s;
endpackage

// ==== temperature_control_output_logic_bench.sv ====
// Self-checking bench of the temperature control output logic.
`timescale 1ns/1ps
module temperature_control_output_logic_bench;
  import tc_pkg::*;
  localparam int DEB = 4;
  logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, relay_dead = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000, rdata, edit_val;
  logic signed [15:0] ta = 16'sh01F4, tb = 16'sh01F4;
  logic [3:0] flt = 4'h0, btn = 4'h0;
  pin_s pins;
  led_s led;
  logic heat, menu, editing;
  int fail_count = 0, tests_run = 0, cyc = 0, menu_n = 0;
  always #20 clk = ~clk;
  tc_far_side far (.clk(clk), .rst_n(rst_n), .temp_a(ta), .temp_b(tb),
    .flt_in(flt), .btn_in(btn), .relay_dead(relay_dead), .heat(heat),
    .pins(pins));
  tc_output_logic #(.SLOW_HALF(8), .FAST_HALF(2), .DEB_CYC(DEB),
    .TEST_CYC(10), .GREEN_CYC(10)) dut (.clk(clk), .rst_n(rst_n),
    .pins(pins), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .led(led), .heat(heat), .menu(menu),
    .editing(editing), .edit_val(edit_val));
  // ---------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // A hung handshake must not stall the run forever.
  always @(posedge clk) begin
    cyc++;
    if (menu === 1'b1) menu_n++;
    if (cyc == 30000) begin
      fail_count++;
      end_of_test();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
      fail_count++;
    end
  endtask
  function automatic logic [15:0] h();
    return {15'h0, heat};
  endfunction
  task automatic wreg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic wr_rd(input logic [7:0] a, input logic [15:0] d,
                       input logic [15:0] exp);
    logic [15:0] got;
    wreg(a, d);
    rreg(a, got);
    chk(got, exp);
  endtask
  task automatic set_t(input logic [15:0] a, input logic [15:0] b,
                       input logic [3:0] f);
    @(posedge clk);
    ta <= a;
    tb <= b;
    flt <= f;
    repeat (20) @(posedge clk);
    #1;
  endtask
  task automatic wait_heat(input logic v);
    int n;
    n = 0;
    while (heat !== v && n < 200) begin
      @(posedge clk);
      #1 n++;
    end
    chk(h(), {15'h0, v});
  endtask
  // Held for well beyond the debounce interval, then fully released.
  task automatic press(input logic [3:0] b);
    @(posedge clk);
    btn <= b;
    repeat (DEB + 6) @(posedge clk);
    btn <= 4'h0;
    repeat (DEB + 6) @(posedge clk);
    #1;
  endtask
  // Kind 0 steady, 1 slow flash, 2 fast flash; told apart by edge count.
  task automatic led_chk(input led_s c, input int kind);
    int on_n, off_n, chg;
    led_s prev;
    on_n = 0;
    off_n = 0;
    chg = 0;
    prev = led;
    repeat (32) begin
      @(posedge clk);
      #1;
      if (led === c) on_n++;
      else if (led === LED_OFF) off_n++;
      if (led !== prev) chg++;
      prev = led;
    end
    tests_run++;
    if (on_n + off_n != 32 || (kind == 0 && on_n != 32) ||
        (kind == 1 && (off_n == 0 || chg > 5)) || (kind == 2 && chg < 10))
    begin
      $display("BAD t=%0t led got %h exp %h", $time, led, c);
      fail_count++;
    end
  endtask
  // ---------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------
  task automatic t_power();
    int n;
    repeat (3) @(posedge clk);
    #1 chk({13'h0, led}, {13'h0, LED_WHITE});
    chk(h(), 16'h0);
    n = 0;
    while (led !== LED_GREEN && n < 50) begin
      @(posedge clk);
      #1 n++;
    end
    chk({13'h0, led}, {13'h0, LED_GREEN});
    repeat (15) @(posedge clk);
    led_chk(LED_GREEN, 0);
    $display("test power done");
  endtask
  task automatic t_regs();
    logic [15:0] d;
    wr_rd(A_RANGE, 16'h0001, RANGE_MIN);
    wr_rd(A_RANGE, 16'h012C, RANGE_MAX);
    wr_rd(A_RANGE, 16'h001E, 16'h001E);
    wr_rd(A_SP, 16'h0BB8, RST_HI);
    wr_rd(A_SP, 16'hFF9C, RST_LO);
    wr_rd(A_SP, 16'h01F4, 16'h01F4);
    wreg(8'h30, 16'h1234);
    rreg(8'h30, d);
    chk(d, 16'h0000);
    $display("test regs done");
  endtask
  task automatic t_two();
    wreg(A_CTRL, 16'h0001);
    set_t(16'h01CC, 16'h01F4, 4'h0);
    wait_heat(1'b1);
    led_chk(LED_BLUE, 1);
    set_t(16'h01FE, 16'h01F4, 4'h0);
    chk(h(), 16'h1);
    set_t(16'h021C, 16'h01F4, 4'h0);
    wait_heat(1'b0);
    led_chk(LED_RED, 1);
    set_t(16'h01EA, 16'h01F4, 4'h0);
    chk(h(), 16'h0);
    set_t(16'h01CC, 16'h01F4, 4'h0);
    wait_heat(1'b1);
    wreg(A_CTRL, 16'h0005);
    set_t(16'h021C, 16'h01F4, 4'h0);
    wait_heat(1'b1);
    wreg(A_CTRL, 16'h0001);
    wait_heat(1'b0);
    $display("test two_point done");
  endtask
  task automatic t_limit();
    wreg(A_CTRL, 16'h0021);
    set_t(16'h01CC, 16'h03E9, 4'h0);
    wait_heat(1'b0);
    led_chk(LED_YELLOW, 1);
    set_t(16'h01CC, 16'h03C0, 4'h0);
    chk(h(), 16'h0);
    set_t(16'h01CC, 16'h03B5, 4'h0);
    wait_heat(1'b1);
    $display("test limiter done");
  endtask
  task automatic t_fault();
    set_t(16'h01CC, 16'h01F4, 4'h1);
    wait_heat(1'b0);
    led_chk(LED_RED, 2);
    press(B_ENTER);
    chk(h(), 16'h0);
    set_t(16'h01CC, 16'h01F4, 4'h0);
    press(B_ENTER);
    wait_heat(1'b1);
    set_t(16'h01CC, 16'h01F4, 4'h4);
    led_chk(LED_PURPLE, 2);
    set_t(16'h01CC, 16'h01F4, 4'h0);
    press(B_ENTER);
    wait_heat(1'b1);
    relay_dead <= 1'b1;
    repeat (20) @(posedge clk);
    wait_heat(1'b0);
    relay_dead <= 1'b0;
    press(B_ENTER);
    wait_heat(1'b1);
    $display("test fault done");
  endtask
  task automatic t_buttons();
    logic [15:0] d;
    int m;
    @(posedge clk);
    btn <= B_UP;
    repeat (2) @(posedge clk);
    btn <= 4'h0;
    repeat (DEB + 8) @(posedge clk);
    #1 chk({15'h0, editing}, 16'h0);
    press(B_UP);
    chk({15'h0, editing}, 16'h1);
    chk(edit_val, 16'h01F5);
    press(B_BACK);
    rreg(A_SP, d);
    chk(d, 16'h01F4);
    wreg(A_HI, 16'h01F4);
    press(B_UP);
    chk(edit_val, 16'h01F4);
    press(B_BACK);
    wreg(A_HI, RST_HI);
    press(B_UP);
    press(B_ENTER);
    chk({15'h0, editing}, 16'h0);
    rreg(A_SP, d);
    chk(d, 16'h01F5);
    wreg(A_SP, 16'h01F4);
    m = menu_n;
    press(B_MENU);
    chk(16'(menu_n - m), 16'h1);
    chk({15'h0, editing}, 16'h0);
    press(B_UPDN);
    wait_heat(1'b0);
    press(B_UPDN);
    wait_heat(1'b1);
    $display("test buttons done");
  endtask
  task automatic t_other_modes();
    wreg(A_CTRL, 16'h0023);
    set_t(16'h0258, 16'h01F4, 4'h0);
    wait_heat(1'b1);
    set_t(16'h0258, 16'h03E9, 4'h0);
    wait_heat(1'b0);
    wreg(A_CTRL, 16'h0009);
    set_t(16'h02BC, 16'h02BC, 4'h0);
    led_chk(LED_GREEN, 0);
    set_t(16'h02BC, 16'h0320, 4'h0);
    wait_heat(1'b1);
    $display("test other_modes done");
  endtask
  // A stepping setpoint would leave the band at once; a ramp stays green at first, then shows blue once it has climbed.
  task automatic t_ramp();
    wreg(A_CTRL, 16'h0001);
    set_t(16'h01F4, 16'h01F4, 4'h0);
    wreg(A_GRAD, 16'h000A);
    wreg(A_SP, 16'h0258);
    repeat (4) @(posedge clk);
    #1 chk({13'h0, led}, {13'h0, LED_GREEN});
    repeat (200) @(posedge clk);
    led_chk(LED_BLUE, 1);
    wait_heat(1'b1);
    $display("test ramp done");
  endtask
  // One shortened minute is 960 cycles; a quarter of it is 240.
  task automatic t_fixed();
    int on_n;
    on_n = 0;
    wr_rd(A_PCT, 16'h0096, PCT_FULL);
    wr_rd(A_PCT, 16'h0019, 16'h0019);
    wreg(A_CTRL, 16'h0002);
    repeat (4) @(posedge clk);
    repeat (960) begin
      @(posedge clk);
      #1 if (heat === 1'b1) on_n++;
    end
    chk(16'(on_n), 16'h00F0);
    $display("test fixed done");
  endtask
  // After an overshoot the switch-off point must move inside the band.
  task automatic t_self();
    wreg(A_CTRL, 16'h0000);
    wreg(A_GRAD, 16'h0000);
    set_t(16'h0226, 16'h01F4, 4'h0);
    wait_heat(1'b1);
    set_t(16'h0280, 16'h01F4, 4'h0);
    wait_heat(1'b0);
    set_t(16'h0226, 16'h01F4, 4'h0);
    wait_heat(1'b1);
    set_t(16'h0276, 16'h01F4, 4'h0);
    wait_heat(1'b0);
    $display("test self_adjusting done");
  endtask
  // ---------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    t_power();
    t_regs();
    t_two();
    t_limit();
    t_fault();
    t_buttons();
    t_other_modes();
    t_ramp();
    t_fixed();
    t_self();
    end_of_test();
  end
endmodule // temperature_control_output_logic_bench
